// file: rtl/cbrf_map.svh
// offsets, field positions and reset values of the banked register file
`ifndef CBRF_MAP_SVH
`define CBRF_MAP_SVH

// ==========================================================
// register byte offsets on the register bus (active bank)
`define CBRF_OFF_DATA_REG_ZERO  8'h00
`define CBRF_OFF_DATA_REG_ONE   8'h04
`define CBRF_OFF_DATA_REG_TWO   8'h08
`define CBRF_OFF_DATA_REG_THREE 8'h0c
`define CBRF_OFF_ADDR_REG_ZERO  8'h10
`define CBRF_OFF_ADDR_REG_ONE   8'h14
`define CBRF_OFF_FRAME_BASE     8'h18
`define CBRF_OFF_STATUS         8'h1c
`define CBRF_ADDR_SPAN          8'h20

// ==========================================================
// storage indices within one bank
`define CBRF_IDX_DATA_REG_ZERO  3'h0
`define CBRF_IDX_DATA_REG_ONE   3'h1
`define CBRF_IDX_DATA_REG_TWO   3'h2
`define CBRF_IDX_DATA_REG_THREE 3'h3
`define CBRF_IDX_ADDR_REG_ZERO  3'h4
`define CBRF_IDX_ADDR_REG_ONE   3'h5
`define CBRF_IDX_FRAME_BASE     3'h6
`define CBRF_IDX_STATUS         3'h7

// ==========================================================
// field positions, reset values and bus responses
`define CBRF_BANK_FLAG_BIT      4
`define CBRF_STAT_BANK_BIT      0
`define CBRF_REG_RST            16'h0000
`define CBRF_RESP_OKAY          2'h0
`define CBRF_RESP_SLVERR        2'h2

`endif

// file: rtl/cbrf_pkg.sv
// types shared by the banked register file modules
package cbrf_pkg;

    // ==========================================================
    // storage types
    typedef logic [15:0]       cbrf_word_t;
    typedef logic [6:0][15:0]  cbrf_bank_t;

    // ==========================================================
    // operand selector used by the datapath read and write ports
    typedef enum logic [3:0] {
        sel_data_reg_zero   = 4'h0,
        sel_data_reg_one    = 4'h1,
        sel_data_reg_two    = 4'h2,
        sel_data_reg_three  = 4'h3,
        sel_addr_reg_zero   = 4'h4,
        sel_addr_reg_one    = 4'h5,
        sel_frame_base      = 4'h6,
        sel_data_zero_low   = 4'h7,
        sel_data_zero_high  = 4'h8,
        sel_data_one_low    = 4'h9,
        sel_data_one_high   = 4'ha,
        sel_data_pair_low   = 4'hb,
        sel_data_pair_high  = 4'hc,
        sel_addr_pair       = 4'hd
    } cbrf_sel_e;

    // ==========================================================
    // register bus channel phases
    typedef enum logic [2:0] {
        ph_idle = 3'b001,
        ph_exec = 3'b010,
        ph_resp = 3'b100
    } cbrf_phase_e;

endpackage

// file: rtl/cbrf_read_select.sv
// operand read selector over one register bank
`timescale 1ns/1ps
module cbrf_read_select
    import cbrf_pkg::*;
(
    // bank contents and selector
    input  wire cbrf_pkg::cbrf_bank_t bank_in,
    input  wire cbrf_pkg::cbrf_sel_e  sel_in,
    // zero-extended operand
    output logic [31:0]               data_out
);

    // ==========================================================
    // selector decode
    always_comb begin
        case (sel_in)
            sel_data_reg_zero:  data_out = {16'h0000, bank_in[0]};
            sel_data_reg_one:   data_out = {16'h0000, bank_in[1]};
            sel_data_reg_two:   data_out = {16'h0000, bank_in[2]};
            sel_data_reg_three: data_out = {16'h0000, bank_in[3]};
            sel_addr_reg_zero:  data_out = {16'h0000, bank_in[4]};
            sel_addr_reg_one:   data_out = {16'h0000, bank_in[5]};
            sel_frame_base:     data_out = {16'h0000, bank_in[6]};
            sel_data_zero_low:  data_out = {24'h000000, bank_in[0][7:0]};
            sel_data_zero_high: data_out = {24'h000000, bank_in[0][15:8]};
            sel_data_one_low:   data_out = {24'h000000, bank_in[1][7:0]};
            sel_data_one_high:  data_out = {24'h000000, bank_in[1][15:8]};
            sel_data_pair_low:  data_out = {bank_in[2], bank_in[0]};
            sel_data_pair_high: data_out = {bank_in[3], bank_in[1]};
            sel_addr_pair:      data_out = {bank_in[5], bank_in[4]};
            default:            data_out = 32'h00000000;
        endcase
    end

endmodule

// file: rtl/cbrf_bank_update.sv
// datapath write merge into one register bank
`timescale 1ns/1ps
module cbrf_bank_update
    import cbrf_pkg::*;
(
    // current bank and write request
    input  wire cbrf_pkg::cbrf_bank_t bank_in,
    input  wire logic                 wr_en_in,
    input  wire cbrf_pkg::cbrf_sel_e  sel_in,
    input  wire logic [31:0]          data_in,
    // bank after the write
    output cbrf_pkg::cbrf_bank_t      bank_out
);

    // ==========================================================
    // merge: byte writes keep the other half, pairs split high/low
    always_comb begin
        bank_out = bank_in;
        if (wr_en_in) begin
            case (sel_in)
                sel_data_reg_zero:  bank_out[0] = data_in[15:0];
                sel_data_reg_one:   bank_out[1] = data_in[15:0];
                sel_data_reg_two:   bank_out[2] = data_in[15:0];
                sel_data_reg_three: bank_out[3] = data_in[15:0];
                sel_addr_reg_zero:  bank_out[4] = data_in[15:0];
                sel_addr_reg_one:   bank_out[5] = data_in[15:0];
                sel_frame_base:     bank_out[6] = data_in[15:0];
                sel_data_zero_low:  bank_out[0][7:0]  = data_in[7:0];
                sel_data_zero_high: bank_out[0][15:8] = data_in[7:0];
                sel_data_one_low:   bank_out[1][7:0]  = data_in[7:0];
                sel_data_one_high:  bank_out[1][15:8] = data_in[7:0];
                sel_data_pair_low: begin
                    bank_out[0] = data_in[15:0];
                    bank_out[2] = data_in[31:16];
                end
                sel_data_pair_high: begin
                    bank_out[1] = data_in[15:0];
                    bank_out[3] = data_in[31:16];
                end
                sel_addr_pair: begin
                    bank_out[4] = data_in[15:0];
                    bank_out[5] = data_in[31:16];
                end
                default: bank_out = bank_in;
            endcase
        end
    end

endmodule

// file: rtl/cbrf_top.sv
// banked general-purpose register file with datapath ports and register bus
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "cbrf_map.svh"

// What this block does
// - thirteen registers; this file holds banked subset
// - seven registers duplicated in two banks
// - four 16-bit data registers, read/write
// - first two data registers split into bytes
// - third/first and fourth/second form 32 bits
// - two 16-bit address registers, full data use
// - address registers feed indirect/relative addressing
// - address pair 32 bits, second one upper
// - 16-bit frame base feeds relative addressing
// - flag bit four selects active bank
module cbrf_top
    import cbrf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic                clk_sys_in,
    input  wire logic                reset_n_in,
    // flag register from the cpu core
    input  wire logic [15:0]         flag_register_in,
    // datapath write port
    input  wire logic                wr_en_in,
    input  wire cbrf_pkg::cbrf_sel_e wr_sel_in,
    input  wire logic [31:0]         wr_data_in,
    // datapath read ports
    input  wire cbrf_pkg::cbrf_sel_e rd_a_sel_in,
    input  wire cbrf_pkg::cbrf_sel_e rd_b_sel_in,
    output logic [31:0]              rd_a_data_out,
    output logic [31:0]              rd_b_data_out,
    // addressing base values of the active bank
    output logic [15:0]              addr_reg_zero_out,
    output logic [15:0]              addr_reg_one_out,
    output logic [31:0]              addr_pair_out,
    output logic [15:0]              frame_base_out,
    output logic                     active_bank_out,
    // register bus write address and data
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // register bus write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // register bus read
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    // ==========================================================
    // state of the whole block
    typedef struct packed {
        logic [1:0][6:0][15:0] banks;
        logic                  bank;
        logic [31:0]           rd_a;
        logic [31:0]           rd_b;
        logic [15:0]           addr0;
        logic [15:0]           addr1;
        logic [15:0]           fbase;
        cbrf_phase_e           wph;
        logic                  aw_got;
        logic                  w_got;
        logic [ADDR_W-1:0]     awaddr;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        cbrf_phase_e           rph;
        logic [ADDR_W-1:0]     araddr;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } cbrf_state_s;

    cbrf_state_s state_ff;
    cbrf_state_s nxt_state;

    cbrf_bank_t  cur_bank;
    cbrf_bank_t  dp_bank;
    cbrf_bank_t  upd_bank;
    logic        use_bank;
    logic [31:0] rd_a_val;
    logic [31:0] rd_b_val;
    logic        bus_wr_take;

    // ==========================================================
    // bus address decode: aligned word inside the map
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        addr_mapped = (addr < ADDR_W'(`CBRF_ADDR_SPAN)) && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] addr_index(input logic [ADDR_W-1:0] addr);
        addr_index = addr[4:2];
    endfunction

    // ==========================================================
    // active bank follows the bank flag; only that bank is touched
    assign use_bank = flag_register_in[`CBRF_BANK_FLAG_BIT];
    assign cur_bank = state_ff.banks[use_bank];

    // operand read selectors
    cbrf_read_select u_rd_a (
        .bank_in  (cur_bank),
        .sel_in   (rd_a_sel_in),
        .data_out (rd_a_val)
    );

    cbrf_read_select u_rd_b (
        .bank_in  (cur_bank),
        .sel_in   (rd_b_sel_in),
        .data_out (rd_b_val)
    );

    // datapath write merge
    cbrf_bank_update u_upd (
        .bank_in  (cur_bank),
        .wr_en_in (wr_en_in),
        .sel_in   (wr_sel_in),
        .data_in  (wr_data_in),
        .bank_out (dp_bank)
    );

    // bus write goes ahead only in a cycle without a datapath write
    assign bus_wr_take = (state_ff.wph == ph_exec) && !wr_en_in;

    // ==========================================================
    // next state
    always_comb begin
        nxt_state = state_ff;
        upd_bank  = dp_bank;

        // bus write into the active bank, honouring low byte lanes
        if (bus_wr_take && addr_mapped(state_ff.awaddr)
            && (addr_index(state_ff.awaddr) != `CBRF_IDX_STATUS)) begin
            if (state_ff.wstrb[0]) begin
                upd_bank[addr_index(state_ff.awaddr)][7:0] = state_ff.wdata[7:0];
            end
            if (state_ff.wstrb[1]) begin
                upd_bank[addr_index(state_ff.awaddr)][15:8] = state_ff.wdata[15:8];
            end
        end
        nxt_state.banks[use_bank] = upd_bank;
        nxt_state.bank            = use_bank;

        // operand reads show the contents before this edge's write
        nxt_state.rd_a = rd_a_val;
        nxt_state.rd_b = rd_b_val;

        // addressing bases show the contents after this edge's write
        nxt_state.addr0 = upd_bank[`CBRF_IDX_ADDR_REG_ZERO];
        nxt_state.addr1 = upd_bank[`CBRF_IDX_ADDR_REG_ONE];
        nxt_state.fbase = upd_bank[`CBRF_IDX_FRAME_BASE];

        // write channel: gather address and data in either order
        case (state_ff.wph)
            ph_idle: begin
                if (s_axi_awvalid && state_ff.awready) begin
                    nxt_state.aw_got = 1'b1;
                    nxt_state.awaddr = s_axi_awaddr;
                end
                if (s_axi_wvalid && state_ff.wready) begin
                    nxt_state.w_got = 1'b1;
                    nxt_state.wdata = s_axi_wdata;
                    nxt_state.wstrb = s_axi_wstrb;
                end
                if (nxt_state.aw_got && nxt_state.w_got) begin
                    nxt_state.wph = ph_exec;
                end
            end
            ph_exec: begin
                if (bus_wr_take) begin
                    nxt_state.wph    = ph_resp;
                    nxt_state.bvalid = 1'b1;
                    nxt_state.bresp  = addr_mapped(state_ff.awaddr) ?
                                       `CBRF_RESP_OKAY : `CBRF_RESP_SLVERR;
                end
            end
            ph_resp: begin
                if (s_axi_bready) begin
                    nxt_state.wph    = ph_idle;
                    nxt_state.bvalid = 1'b0;
                    nxt_state.aw_got = 1'b0;
                    nxt_state.w_got  = 1'b0;
                end
            end
            default: begin
                nxt_state.wph    = ph_idle;
                nxt_state.bvalid = 1'b0;
                nxt_state.aw_got = 1'b0;
                nxt_state.w_got  = 1'b0;
            end
        endcase
        nxt_state.awready = (nxt_state.wph == ph_idle) && !nxt_state.aw_got;
        nxt_state.wready  = (nxt_state.wph == ph_idle) && !nxt_state.w_got;

        // read channel: one cycle to fetch, then hold until taken
        case (state_ff.rph)
            ph_idle: begin
                if (s_axi_arvalid && state_ff.arready) begin
                    nxt_state.araddr  = s_axi_araddr;
                    nxt_state.arready = 1'b0;
                    nxt_state.rph     = ph_exec;
                end
            end
            ph_exec: begin
                nxt_state.rvalid = 1'b1;
                nxt_state.rph    = ph_resp;
                if (!addr_mapped(state_ff.araddr)) begin
                    nxt_state.rdata = 32'h00000000;
                    nxt_state.rresp = `CBRF_RESP_SLVERR;
                end else if (addr_index(state_ff.araddr) == `CBRF_IDX_STATUS) begin
                    nxt_state.rdata = 32'h00000000;
                    nxt_state.rdata[`CBRF_STAT_BANK_BIT] = use_bank;
                    nxt_state.rresp = `CBRF_RESP_OKAY;
                end else begin
                    nxt_state.rdata = {16'h0000, cur_bank[addr_index(state_ff.araddr)]};
                    nxt_state.rresp = `CBRF_RESP_OKAY;
                end
            end
            ph_resp: begin
                if (s_axi_rready) begin
                    nxt_state.rvalid  = 1'b0;
                    nxt_state.arready = 1'b1;
                    nxt_state.rph     = ph_idle;
                end
            end
            default: begin
                nxt_state.rvalid  = 1'b0;
                nxt_state.arready = 1'b1;
                nxt_state.rph     = ph_idle;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff.banks   <= {14{`CBRF_REG_RST}};
            state_ff.bank    <= 1'b0;
            state_ff.rd_a    <= 32'h00000000;
            state_ff.rd_b    <= 32'h00000000;
            state_ff.addr0   <= `CBRF_REG_RST;
            state_ff.addr1   <= `CBRF_REG_RST;
            state_ff.fbase   <= `CBRF_REG_RST;
            state_ff.wph     <= ph_idle;
            state_ff.aw_got  <= 1'b0;
            state_ff.w_got   <= 1'b0;
            state_ff.awaddr  <= '0;
            state_ff.wdata   <= 32'h00000000;
            state_ff.wstrb   <= 4'h0;
            state_ff.awready <= 1'b1;
            state_ff.wready  <= 1'b1;
            state_ff.bvalid  <= 1'b0;
            state_ff.bresp   <= `CBRF_RESP_OKAY;
            state_ff.rph     <= ph_idle;
            state_ff.araddr  <= '0;
            state_ff.arready <= 1'b1;
            state_ff.rvalid  <= 1'b0;
            state_ff.rdata   <= 32'h00000000;
            state_ff.rresp   <= `CBRF_RESP_OKAY;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    assign rd_a_data_out     = state_ff.rd_a;
    assign rd_b_data_out     = state_ff.rd_b;
    assign addr_reg_zero_out = state_ff.addr0;
    assign addr_reg_one_out  = state_ff.addr1;
    assign addr_pair_out     = {state_ff.addr1, state_ff.addr0};
    assign frame_base_out    = state_ff.fbase;
    assign active_bank_out   = state_ff.bank;
    assign s_axi_awready     = state_ff.awready;
    assign s_axi_wready      = state_ff.wready;
    assign s_axi_bresp       = state_ff.bresp;
    assign s_axi_bvalid      = state_ff.bvalid;
    assign s_axi_arready     = state_ff.arready;
    assign s_axi_rdata       = state_ff.rdata;
    assign s_axi_rresp       = state_ff.rresp;
    assign s_axi_rvalid      = state_ff.rvalid;

endmodule

// file: sim/cbrf_monitor.sv
// concurrent checks on the banked register file ports
`timescale 1ns/1ps
module cbrf_monitor
    import cbrf_pkg::*;
(
    // observed ports of the register file
    input wire logic                clk_sys_in, reset_n_in, wr_en_in, active_bank_out,
    input wire logic [15:0]         flag_register_in, addr_reg_zero_out, addr_reg_one_out,
    input wire logic [15:0]         frame_base_out,
    input wire cbrf_pkg::cbrf_sel_e wr_sel_in, rd_a_sel_in, rd_b_sel_in,
    input wire logic [31:0]         wr_data_in, rd_a_data_out, rd_b_data_out, addr_pair_out,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic                s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]          s_axi_bresp
);
    // ==========================================================
    // single clock domain
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    AST_ADDR_ZERO_WRITE: assert property (wr_en_in && wr_sel_in == sel_addr_reg_zero
        |=> addr_reg_zero_out == $past(wr_data_in[15:0])) else $error("addr zero base wrong");
    AST_FRAME_WRITE: assert property (wr_en_in && wr_sel_in == sel_frame_base
        |=> frame_base_out == $past(wr_data_in[15:0])) else $error("frame base wrong");
    AST_PAIR_JOIN: assert property (addr_pair_out == {addr_reg_one_out, addr_reg_zero_out})
        else $error("address pair not joined");
    AST_PAIR_WRITE: assert property (wr_en_in && wr_sel_in == sel_addr_pair
        |=> addr_reg_one_out == $past(wr_data_in[31:16])
        && addr_reg_zero_out == $past(wr_data_in[15:0])) else $error("pair write wrong");
    AST_BANK_FLAG: assert property ($past(reset_n_in)
        |-> active_bank_out == $past(flag_register_in[4])) else $error("bank not followed");
    AST_BYTE_ZEXT: assert property (rd_a_sel_in == sel_data_zero_high
        |=> rd_a_data_out[31:8] == 24'h000000) else $error("byte read not extended");
    AST_PORTS_AGREE: assert property (rd_a_sel_in == rd_b_sel_in
        |=> rd_a_data_out == rd_b_data_out) else $error("read ports disagree");
    AST_READ_RESP: assert property (s_axi_arvalid && s_axi_arready
        |=> !s_axi_rvalid ##1 s_axi_rvalid) else $error("read answer late");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");

    // main scenarios reached
    COV_PAIR: cover property (wr_en_in && wr_sel_in == sel_data_pair_high);
    COV_BANK: cover property ($rose(active_bank_out));
    COV_BUS_WR: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind cbrf_top cbrf_monitor cbrf_monitor_i (.*);

// file: sim/cbrf_dp_model.sv
// datapath-side partner model
`timescale 1ns/1ps
module cbrf_dp_model
    import cbrf_pkg::*;
(
    // clock and read results
    input  wire logic           clk_sys_in,
    input  wire logic [31:0]    rd_a_data_in,
    input  wire logic [31:0]    rd_b_data_in,
    // requests towards the register file
    output logic [15:0]         flag_register_out,
    output logic                wr_en_out,
    output cbrf_pkg::cbrf_sel_e wr_sel_out,
    output logic [31:0]         wr_data_out,
    output cbrf_pkg::cbrf_sel_e rd_a_sel_out,
    output cbrf_pkg::cbrf_sel_e rd_b_sel_out
);
    // ==========================================================
    // idle values at time zero
    initial begin
        {flag_register_out, wr_en_out, wr_data_out} = 49'h0;
        wr_sel_out = sel_data_reg_zero;
        rd_a_sel_out = sel_data_reg_zero;
        rd_b_sel_out = sel_data_reg_zero;
    end
    // one write pulse, then data inverted
    task automatic wr(input cbrf_sel_e s, input logic [31:0] d);
        @(posedge clk_sys_in);
        wr_en_out <= 1'b1;
        wr_sel_out <= s;
        wr_data_out <= d;
        @(posedge clk_sys_in);
        wr_en_out <= 1'b0;
        wr_data_out <= ~d;
    endtask
    // select both read ports, result one edge later
    task automatic rd(input cbrf_sel_e s, output logic [31:0] a, output logic [31:0] b);
        @(posedge clk_sys_in);
        rd_a_sel_out <= s;
        rd_b_sel_out <= s;
        repeat (2) @(posedge clk_sys_in);
        a = rd_a_data_in;
        b = rd_b_data_in;
    endtask
    // bank bit, other flag bits as noise
    task automatic bank(input logic b);
        @(posedge clk_sys_in);
        flag_register_out <= {11'h000, b, 4'h5};
    endtask
endmodule

// file: sim/tb_top.sv
// bench of the banked register file
`timescale 1ns/1ps
module tb_top;
    import cbrf_pkg::*;
    // ==========================================================
    // signals
    logic        clk_sys_in = 1'b0, reset_n_in = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_a, rd_b, wr_data, ad_pair, q;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, wr_en, act_bank;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [15:0] flag, a0, a1, fb;
    cbrf_sel_e   wr_sel, rd_a_sel, rd_b_sel;
    int          mismatches = 0, cmp_count = 0;

    cbrf_top #(.ADDR_W(8)) cbrf_top_i (.clk_sys_in, .reset_n_in, .flag_register_in(flag),
        .wr_en_in(wr_en), .wr_sel_in(wr_sel), .wr_data_in(wr_data), .rd_a_sel_in(rd_a_sel),
        .rd_b_sel_in(rd_b_sel), .rd_a_data_out(rd_a), .rd_b_data_out(rd_b),
        .addr_reg_zero_out(a0), .addr_reg_one_out(a1), .addr_pair_out(ad_pair),
        .frame_base_out(fb), .active_bank_out(act_bank), .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    cbrf_dp_model cbrf_dp_model_i (.clk_sys_in, .rd_a_data_in(rd_a), .rd_b_data_in(rd_b),
        .flag_register_out(flag), .wr_en_out(wr_en), .wr_sel_out(wr_sel),
        .wr_data_out(wr_data), .rd_a_sel_out(rd_a_sel), .rd_b_sel_out(rd_b_sel));

    // 25 MHz clock
    initial forever #20 clk_sys_in = ~clk_sys_in;

    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus transfer, w selects write
    task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
        while (!(w ? s_axi_bvalid : s_axi_rvalid)) begin
            @(posedge clk_sys_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        {s_axi_bready, s_axi_rready} <= {w, !w};
        @(posedge clk_sys_in);
        q = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask
    task automatic rdc(input cbrf_sel_e s, input logic [31:0] e);
        logic [31:0] a, b;
        cbrf_dp_model_i.rd(s, a, b);
        check(a, e);
        check(b, e);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            axi(0, 8'(i * 4), 32'h0);
            check(q, 32'h0);
        end
        axi(0, 8'h20, 32'h0);
        check(q, 32'h0);
        check(32'(r), 32'h2);
    endtask
    task automatic t_words();
        for (int i = 0; i < 7; i++) cbrf_dp_model_i.wr(cbrf_sel_e'(i), {16'hdead, 16'(i)});
        for (int i = 0; i < 7; i++) begin
            rdc(cbrf_sel_e'(i), 32'(i));
            axi(0, 8'(i * 4), 32'h0);
            check(q, 32'(i));
        end
        check({a0, a1}, {16'h4, 16'h5});
        check(32'(fb), 32'h6);
    endtask
    task automatic t_bytes();
        for (int k = 0; k < 2; k++) begin
            cbrf_dp_model_i.wr(cbrf_sel_e'(k), 32'h1234);
            cbrf_dp_model_i.wr(cbrf_sel_e'(8 + 2 * k), 32'hffff00ab);
            rdc(cbrf_sel_e'(k), 32'hab34);
            cbrf_dp_model_i.wr(cbrf_sel_e'(7 + 2 * k), 32'h000000cd);
            rdc(cbrf_sel_e'(k), 32'habcd);
            rdc(cbrf_sel_e'(8 + 2 * k), 32'hab);
            rdc(cbrf_sel_e'(7 + 2 * k), 32'hcd);
        end
    endtask
    task automatic t_pairs();
        cbrf_dp_model_i.wr(sel_data_pair_low, 32'h11112222);
        cbrf_dp_model_i.wr(sel_data_pair_high, 32'h33334444);
        cbrf_dp_model_i.wr(sel_addr_pair, 32'h55556666);
        rdc(sel_data_reg_two, 32'h1111);
        rdc(sel_data_reg_zero, 32'h2222);
        rdc(sel_data_reg_three, 32'h3333);
        rdc(sel_data_pair_high, 32'h33334444);
        rdc(sel_addr_reg_one, 32'h5555);
        check(ad_pair, 32'h55556666);
        check(32'(a1), 32'h5555);
    endtask
    task automatic t_banks();
        cbrf_dp_model_i.bank(1'b1);
        rdc(sel_frame_base, 32'h0);
        cbrf_dp_model_i.wr(sel_frame_base, 32'h2222);
        rdc(sel_frame_base, 32'h2222);
        axi(0, 8'h1c, 32'h0);
        check(q, 32'h1);
        check(32'(act_bank), 32'h1);
        cbrf_dp_model_i.bank(1'b0);
        rdc(sel_frame_base, 32'h6);
    endtask
    task automatic t_bus();
        axi(1, 8'h18, 32'hffff5a5a);
        check(32'(r), 32'h0);
        rdc(sel_frame_base, 32'h5a5a);
        s_axi_wstrb <= 4'h2;
        axi(1, 8'h18, 32'h0000c3ff);
        rdc(sel_frame_base, 32'hc35a);
        axi(1, 8'h21, 32'h1);
        check(32'(r), 32'h2);
        axi(1, 8'h1c, 32'h1);
        axi(0, 8'h1c, 32'h0);
        check(q, 32'h0);
        check(32'(r), 32'h0);
    endtask

    // ==========================================================
    // verdict and run control
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_words();
        t_bytes();
        t_pairs();
        t_banks();
        t_bus();
        summarize();
    end
endmodule
